//--- rtl/acc_defs.svh
// Offsets, field positions, reset values and timing counts for the
// analog comparator control block.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// Register byte addresses
`define ACC_SFIO_ADDR 8'h00
`define ACC_CSR_ADDR 8'h04
`define ACC_EXT_ADDR 8'h08

// Special function register fields
`define ACC_SFIO_MUXEN 3
`define ACC_SFIO_RESET 8'h00
`define ACC_SFIO_RWMASK 8'hef

// Comparator control/status fields
`define ACC_CSR_OFF 7
`define ACC_CSR_BG 6
`define ACC_CSR_RES 5
`define ACC_CSR_FLAG 4
`define ACC_CSR_IEN 3
`define ACC_CSR_CAP 2
`define ACC_CSR_MODEHI 1
`define ACC_CSR_MODELO 0
`define ACC_CSR_RESET 8'h00

// Converter-side register: enable bit and mux field
`define ACC_EXT_CONVEN 7
`define ACC_EXT_SEL_LO 0
`define ACC_EXT_RESET 8'h00

// Synchronizer depth in system clock cycles
`define ACC_SYNC_STAGES 2

`endif

//--- rtl/acc_pkg.sv
// Types shared by the analog comparator control block.
// Assumes the constants of acc_defs.svh are included where needed.
package acc_pkg;

  // Interrupt event selection, in binary order as printed
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'h0,
    ACC_MODE_RSVD = 2'h1,
    ACC_MODE_FALL = 2'h2,
    ACC_MODE_RISE = 2'h3
  } acc_mode_t;

endpackage : acc_pkg

//--- rtl/acc_sync.sv
// Two-stage synchronizer with edge outputs for the comparator result.
// Assumes the raw comparator level is asynchronous to clk_sys.
`timescale 1ns/100ps
`include "acc_defs.svh"

module acc_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Raw level in
  input wire logic rawLevel,
  // Synchronized level and edges
  output logic syncLevel,
  output logic riseEdge,
  output logic fallEdge
);

  logic [`ACC_SYNC_STAGES-1:0] stages;
  logic [`ACC_SYNC_STAGES-1:0] next_stages;
  logic prevLevel;
  logic next_prevLevel;

  // Shift chain; only the second stage is looked at
  always_comb begin
    next_stages = {stages[`ACC_SYNC_STAGES-2:0], rawLevel};
    next_prevLevel = stages[`ACC_SYNC_STAGES-1];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stages <= '0;
      prevLevel <= 1'b0;
    end else begin
      stages <= next_stages;
      prevLevel <= next_prevLevel;
    end
  end

  // Compare successive synchronized samples
  assign syncLevel = stages[`ACC_SYNC_STAGES-1];
  assign riseEdge = syncLevel & ~prevLevel;
  assign fallEdge = ~syncLevel & prevLevel;

endmodule : acc_sync

//--- rtl/acc_analog_comparator_control.sv
// Control logic around the on-chip analog comparator: input selection,
// result synchronization, event flag and capture routing.
// Assumes a classic Wishbone master on clk_sys and an analog core that
// takes the select outputs as plain levels.
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "acc_defs.svh"

// Function
// - With mux enable set and the converter off, mux field picks pin 0-7.
// - With mux enable clear or converter on, the dedicated pin is used.
// - Mux enable is read/write bit 3 of the special register, reset 0.
// - Writing one to the disable bit 7 powers the comparator down.
// - Bandgap select bit 6 picks bandgap or dedicated positive pin.
// - The result reads as bit 5 through a one-to-two cycle synchronizer.
// - The flag bit 4 sets on an event matching the mode bits.
// - The flag clears on vector execution or when software writes one.
// - The request stands only with enable bit 3 and global enable set.
// - Capture enable bit 2 routes the result to the timer capture input.
// - Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - The converter enable bit means the converter owns the mux.
module acc_analog_comparator_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog comparator core
  input wire logic cmpRawOut,
  output logic cmpPowerOff,
  output logic bandgapSelect,
  output logic negUseConverterPin,
  output logic [7:0] converterPinSelect,
  // Timer capture front end
  output logic captureTrigger,
  output logic captureRouted,
  // Interrupt controller
  input wire logic globalIrqEnable,
  input wire logic irqVectorTaken,
  output logic cmpIrqRequest
);

  // Register state
  logic [7:0] sfio;
  logic [7:0] next_sfio;
  logic [7:0] csr;
  logic [7:0] next_csr;
  logic [7:0] extReg;
  logic [7:0] next_extReg;
  logic ack;
  logic next_ack;
  logic [31:0] rdData;
  logic [31:0] next_rdData;

  // Synchronizer outputs
  logic cmpResult;
  logic cmpRise;
  logic cmpFall;

  // Decoded access
  logic busReq;
  logic wrStrobe;
  logic hitSfio;
  logic hitCsr;
  logic hitExt;
  logic eventHit;
  logic flagClear;
  logic converterEnable;
  logic cmpMuxEnable;
  logic [2:0] inputSelectField;
  acc_pkg::acc_mode_t irqMode;

  // One-hot decode of the converter pin index for the pin select output
  function automatic logic [7:0] acc_onehot(input logic [2:0] idx);
    acc_onehot = 8'h01 << idx;
  endfunction : acc_onehot

  acc_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .rawLevel(cmpRawOut),
    .syncLevel(cmpResult),
    .riseEdge(cmpRise),
    .fallEdge(cmpFall)
  );

  // Field views
  assign cmpMuxEnable = sfio[`ACC_SFIO_MUXEN];
  assign converterEnable = extReg[`ACC_EXT_CONVEN];
  assign inputSelectField = extReg[`ACC_EXT_SEL_LO +: 3];
  assign irqMode = acc_pkg::acc_mode_t'(csr[`ACC_CSR_MODEHI:`ACC_CSR_MODELO]);

  // Bus decode; only byte lane 0 carries register data
  assign busReq = wb_cyc_i & wb_stb_i & ~ack;
  assign wrStrobe = busReq & wb_we_i & wb_sel_i[0];
  assign hitSfio = wb_adr_i == `ACC_SFIO_ADDR;
  assign hitCsr = wb_adr_i == `ACC_CSR_ADDR;
  assign hitExt = wb_adr_i == `ACC_EXT_ADDR;

  // Event match; reserved mode never fires
  always_comb begin
    unique case (irqMode)
      acc_pkg::ACC_MODE_TOGGLE: eventHit = cmpRise | cmpFall;
      acc_pkg::ACC_MODE_RSVD: eventHit = 1'b0;
      acc_pkg::ACC_MODE_FALL: eventHit = cmpFall;
      acc_pkg::ACC_MODE_RISE: eventHit = cmpRise;
    endcase
  end

  // Write-one-to-clear or vector execution clears the flag
  assign flagClear = irqVectorTaken
    | (wrStrobe & hitCsr & wb_dat_i[`ACC_CSR_FLAG]);

  // Next register values; a new event beats a clear in the same cycle
  always_comb begin
    next_sfio = sfio;
    next_csr = csr;
    next_extReg = extReg;
    if (wrStrobe && hitSfio) begin
      next_sfio = wb_dat_i[7:0] & `ACC_SFIO_RWMASK;
    end
    if (wrStrobe && hitCsr) begin
      // Bits 7,6,3,2,1,0 writable; result is read-only
      next_csr[`ACC_CSR_OFF] = wb_dat_i[`ACC_CSR_OFF];
      next_csr[`ACC_CSR_BG] = wb_dat_i[`ACC_CSR_BG];
      next_csr[`ACC_CSR_IEN] = wb_dat_i[`ACC_CSR_IEN];
      next_csr[`ACC_CSR_CAP] = wb_dat_i[`ACC_CSR_CAP];
      next_csr[`ACC_CSR_MODEHI] = wb_dat_i[`ACC_CSR_MODEHI];
      next_csr[`ACC_CSR_MODELO] = wb_dat_i[`ACC_CSR_MODELO];
    end
    if (wrStrobe && hitExt) begin
      next_extReg = wb_dat_i[7:0];
    end
    next_csr[`ACC_CSR_RES] = 1'b0;
    if (flagClear) begin
      next_csr[`ACC_CSR_FLAG] = 1'b0;
    end
    if (eventHit) begin
      next_csr[`ACC_CSR_FLAG] = 1'b1;
    end
  end

  // Bus answer: ack one cycle after the request, dropped the next cycle
  always_comb begin
    next_ack = busReq;
    next_rdData = rdData;
    if (busReq && !wb_we_i) begin
      next_rdData = 32'h0000_0000;
      if (hitSfio) begin
        next_rdData[7:0] = sfio;
      end else if (hitCsr) begin
        next_rdData[7:0] = {csr[7:6], cmpResult, csr[4:0]};
      end else if (hitExt) begin
        next_rdData[7:0] = extReg;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sfio <= `ACC_SFIO_RESET;
      csr <= `ACC_CSR_RESET;
      extReg <= `ACC_EXT_RESET;
      ack <= 1'b0;
      rdData <= 32'h0000_0000;
    end else begin
      sfio <= next_sfio;
      csr <= next_csr;
      extReg <= next_extReg;
      ack <= next_ack;
      rdData <= next_rdData;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdData;

  // Analog selects; the converter pin is used only when it is free
  assign negUseConverterPin = cmpMuxEnable & ~converterEnable;
  assign converterPinSelect = negUseConverterPin
    ? acc_onehot(inputSelectField) : 8'h00;
  assign cmpPowerOff = csr[`ACC_CSR_OFF];
  assign bandgapSelect = csr[`ACC_CSR_BG];

  // Capture path is gated off entirely when not routed
  assign captureRouted = csr[`ACC_CSR_CAP];
  assign captureTrigger = cmpResult & csr[`ACC_CSR_CAP];

  // Request follows flag, local enable and global enable
  assign cmpIrqRequest = csr[`ACC_CSR_FLAG] & csr[`ACC_CSR_IEN]
    & globalIrqEnable;

endmodule : acc_analog_comparator_control

//--- bench/acc_chk.sv
// Port checker for the comparator control block.
// Assumes a bind to the top module; sees its ports only.
`timescale 1ns/100ps
module acc_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Comparator and capture
  input wire logic cmpRawOut,
  input wire logic cmpPowerOff,
  input wire logic bandgapSelect,
  input wire logic negUseConverterPin,
  input wire logic [7:0] converterPinSelect,
  input wire logic captureTrigger,
  input wire logic captureRouted,
  // Interrupt
  input wire logic globalIrqEnable,
  input wire logic irqVectorTaken,
  input wire logic cmpIrqRequest
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic req;
  // Request seen on the bus
  assign req = wb_cyc_i && wb_stb_i;
  AST_ACK: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_MUX: assert property (
    negUseConverterPin |-> $onehot(converterPinSelect))
    else $error("pin select not one-hot");
  AST_NEG: assert property (!negUseConverterPin |-> !converterPinSelect)
    else $error("pin select while unused");
  AST_REQ: assert property (cmpIrqRequest |-> globalIrqEnable)
    else $error("request without global enable");
  // Two flops from raw to the routed result
  AST_SYNC: assert property (captureRouted |->
    captureTrigger == $past(cmpRawOut, 2))
    else $error("routed result lag wrong");
  // A request only drops for a vector, a write or the global gate
  AST_FALL: assert property ($fell(cmpIrqRequest) |->
    $past(irqVectorTaken) || $past(req) || !globalIrqEnable)
    else $error("request dropped without cause");
  AST_RISE: assert property ($rose(cmpIrqRequest) |->
    $rose(globalIrqEnable) || $past(req) ||
    $past(cmpRawOut, 3) != $past(cmpRawOut, 4) ||
    $past(cmpRawOut, 2) != $past(cmpRawOut, 3))
    else $error("request rose without event");
  CVR_IRQ: cover property (cmpIrqRequest);
  CVR_CAP: cover property (captureTrigger);
  CVR_MUX: cover property (negUseConverterPin);
endmodule : acc_chk

bind acc_analog_comparator_control acc_chk acc_chk_inst (.*);

//--- bench/acc_cmp_model.sv
// Behavioural comparator core: picks pin or reference level.
// Assumes the bench drives the analog levels as plain logic.
`timescale 1ns/100ps
module acc_cmp_model (
  // Controls from the block
  input wire logic cmpPowerOff,
  input wire logic bandgapSelect,
  // Analog stand-ins
  input wire logic pinLevel,
  input wire logic refLevel,
  // Raw result
  output logic cmpRawOut
);
  // Unpowered core reads low, so no stale result survives
  assign cmpRawOut = cmpPowerOff ? 1'b0 :
    (bandgapSelect ? refLevel : pinLevel);
endmodule : acc_cmp_model

//--- bench/acc_tb.sv
// Self-checking bench for the comparator control block.
// Assumes the design answers each bus request with a one-cycle ack.
`timescale 1ns/100ps
module testbench;
  logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, converterPinSelect;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic cmpRawOut, cmpPowerOff, bandgapSelect, negUseConverterPin;
  logic captureTrigger, captureRouted, cmpIrqRequest;
  logic globalIrqEnable, irqVectorTaken, pinLevel, refLevel, ex;
  logic [15:0] seed;
  int err_count, cmp_count, k;
  acc_analog_comparator_control acc_analog_comparator_control_inst (.*);
  acc_cmp_model acc_cmp_model_inst (.cmpPowerOff(cmpPowerOff),
    .bandgapSelect(bandgapSelect), .pinLevel(pinLevel),
    .refLevel(refLevel), .cmpRawOut(cmpRawOut));
  // Next random value
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Whether a rising or falling edge sets the flag in a mode
  function automatic logic hit(input logic [1:0] m, input logic up);
    return m == 2'h0 || m == {1'b1, up};
  endfunction : hit
  task automatic check(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // One classic cycle; held until ack, bounded wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk_sys);
    if (i == 20) begin
      err_count++;
      report_and_stop();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 43'h000_0000_0000;
    {wb_sel_i, globalIrqEnable, irqVectorTaken, pinLevel, refLevel} = 8'hf8;
    seed = 16'h95c0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    bus(0, 8'h04, 0);
    check("csr", rd, 0);
    bus(0, 8'h0c, 0);
    check("unmapped", rd, 0);
    bus(1, 8'h00, 32'h08);
    wb_sel_i <= 4'he;
    bus(1, 8'h00, 0);
    wb_sel_i <= 4'hf;
    bus(0, 8'h00, 0);
    check("sfio", rd, 32'h08);
    // Every pin, then converter on
    for (k = 0; k < 16; k++) begin
      bus(1, 8'h08, {24'h0, k[3], 4'h0, k[2:0]});
      @(posedge clk_sys);
      check("neg", negUseConverterPin, !k[3]);
      check("pin", converterPinSelect, k[3] ? 0 : 8'h01 << k[2:0]);
    end
    bus(1, 8'h04, 32'hc4);
    @(posedge clk_sys);
    check("ctl", {cmpPowerOff, bandgapSelect, captureRouted}, 7);
    // Random levels through the selected input
    for (k = 0; k < 24; k++) begin
      seed = lfsr(seed);
      pinLevel <= seed[0];
      refLevel <= seed[1];
      bus(1, 8'h04, {25'h0, seed[2], 6'h14});
      repeat (3) @(posedge clk_sys);
      ex = seed[2] ? seed[1] : seed[0];
      bus(0, 8'h04, 0);
      check("res", rd[5], ex);
      // The bench stands in for the timer side, whose capture interrupt
      // enable software sets before relying on the routed result
      check("cap", captureTrigger, ex);
    end
    // Each mode with the enable kept low while it changes
    for (k = 0; k < 4; k++) begin
      pinLevel <= 1'b0;
      repeat (5) @(posedge clk_sys);
      bus(1, 8'h04, 32'h10 | k);
      pinLevel <= 1'b1;
      repeat (5) @(posedge clk_sys);
      bus(0, 8'h04, 0);
      check("rise", rd[4], hit(k[1:0], 1'b1));
      bus(1, 8'h04, 32'h10 | k);
      bus(0, 8'h04, 0);
      check("w1c", rd[4], 0);
      pinLevel <= 1'b0;
      repeat (5) @(posedge clk_sys);
      bus(0, 8'h04, 0);
      check("fall", rd[4], hit(k[1:0], 1'b0));
    end
    bus(1, 8'h04, 32'h18);
    pinLevel <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check("irq", cmpIrqRequest, 1);
    globalIrqEnable <= 1'b0;
    @(posedge clk_sys);
    check("gate", cmpIrqRequest, 0);
    globalIrqEnable <= 1'b1;
    irqVectorTaken <= 1'b1;
    @(posedge clk_sys);
    irqVectorTaken <= 1'b0;
    @(posedge clk_sys);
    check("vec", cmpIrqRequest, 0);
    bus(1, 8'h04, 0);
    bus(1, 8'h04, 32'h80);
    bus(0, 8'h04, 0);
    check("off", rd[7:5], 3'h4);
    report_and_stop();
  end
endmodule : testbench
